// >>> logic/lam_pkg.sv
// Purpose: Shared constants for the limit, alert and power-mode block
// Assumes: 16-bit registers on a decoded word-wide register port
// Notes:   Offsets are word addresses of the register port
package lam_pkg;

  localparam int DW = 16;
  localparam int AW = 8;
  localparam int NUM_THR = 6;
  localparam int THR_IW = 3;

  // Register word addresses
  localparam logic [AW-1:0] ADDR_GENERAL_SETUP = 8'h00;
  localparam logic [AW-1:0] ADDR_CONV_SETUP    = 8'h01;
  localparam logic [AW-1:0] ADDR_DIAG_FLAGS    = 8'h0B;
  localparam logic [AW-1:0] ADDR_THR_BASE      = 8'h0C;
  localparam logic [AW-1:0] ADDR_THR_LAST      = 8'h11;

  // Threshold entry indices
  localparam int TH_CUR_LO = 0;
  localparam int TH_CUR_HI = 1;
  localparam int TH_VBUS_HI = 2;
  localparam int TH_VBUS_LO = 3;
  localparam int TH_DIE_HOT = 4;
  localparam int TH_PWR_MAX = 5;

  // Threshold reset values, entry 0 in the low word
  localparam logic [NUM_THR-1:0][DW-1:0] THR_RST = {
    16'h7FFF,   // power_ceiling_threshold
    16'hFFFF,   // die_hot_threshold
    16'h0000,   // vbus_low_threshold
    16'h7FFF,   // vbus_high_threshold
    16'h7FFF,   // current_high_threshold
    16'h8000    // current_low_threshold
  };

  // general_setup_reg fields
  localparam int GEN_SOFT_RESET_BIT = 15;
  localparam logic [DW-1:0] GEN_SETUP_RST = 16'h0000;

  // conversion_setup_reg fields
  localparam int CONV_MODE_LSB = 0;
  localparam int CONV_MODE_W = 2;
  localparam logic [DW-1:0] CONV_SETUP_RST = 16'h0002;
  localparam logic [CONV_MODE_W-1:0] MODE_SHUTDOWN   = 2'h0;
  localparam logic [CONV_MODE_W-1:0] MODE_TRIGGERED  = 2'h1;
  localparam logic [CONV_MODE_W-1:0] MODE_CONTINUOUS = 2'h2;

  // diag_flags_reg bit positions
  localparam int DG_HOLD_EN    = 15;
  localparam int DG_DONE_AL_EN = 14;
  localparam int DG_AVG_CMP_EN = 13;
  localparam int DG_LEVEL_SEL  = 12;
  localparam int DG_ENERGY_OVF = 11;
  localparam int DG_COULOMB_OVF = 10;
  localparam int DG_ARITH_OVF  = 9;
  localparam int DG_TRIM_OK    = 8;
  localparam int DG_LIM_LSB    = 2;
  localparam int DG_DONE       = 1;
  localparam logic [3:0] DIAG_CTRL_RST = 4'h0;

  // Limit flag order inside the six-bit limit vector
  localparam int LF_CUR_UNDER = 0;
  localparam int LF_CUR_OVER  = 1;
  localparam int LF_VBUS_HIGH = 2;
  localparam int LF_VBUS_LOW  = 3;
  localparam int LF_DIE_HOT   = 4;
  localparam int LF_PWR_EXCESS = 5;

  typedef enum logic [1:0] {
    LAM_SHUT,
    LAM_TRIG,
    LAM_CONT
  } lam_conv_e;

endpackage : lam_pkg

// >>> logic/lam_thr_if.sv
// Purpose: Carrier between the control logic and the threshold store
// Assumes: One clock domain
// Notes:   All six limits are visible in parallel for comparison
`timescale 1ns/1ps
interface lam_thr_if;
  logic                                        clear;
  logic                                        we;
  logic [lam_pkg::THR_IW-1:0]                  waddr;
  logic [lam_pkg::DW-1:0]                      wdata;
  logic [lam_pkg::THR_IW-1:0]                  raddr;
  logic [lam_pkg::DW-1:0]                      rdata;
  logic [lam_pkg::NUM_THR-1:0][lam_pkg::DW-1:0] thr;

  modport ctrl  (output clear, we, waddr, wdata, raddr, input rdata, thr);
  modport store (input clear, we, waddr, wdata, raddr, output rdata, thr);
endinterface : lam_thr_if

// >>> logic/lam_thr_regs.sv
// Purpose: Six signed threshold words with registered read data
// Assumes: clear is the combined power-on and soft reset
// Notes:   Unused index reads give zero
`timescale 1ns/1ps
module lam_thr_regs (
  // Clock; reset arrives as clear on the carrier
  input  wire logic ref_clk,
  // Store side of the carrier
  lam_thr_if.store  tb
);

  genvar gi;
  generate
    for (gi = 0; gi < lam_pkg::NUM_THR; gi++) begin : g_thr
      always_ff @(posedge ref_clk) begin
        if (tb.clear) begin
          tb.thr[gi] <= lam_pkg::THR_RST[gi];
        end else if (tb.we && (tb.waddr == lam_pkg::THR_IW'(gi))) begin
          tb.thr[gi] <= tb.wdata;
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (tb.clear) begin
      tb.rdata <= '0;
    end else if (tb.raddr < lam_pkg::THR_IW'(lam_pkg::NUM_THR)) begin
      tb.rdata <= tb.thr[tb.raddr];
    end else begin
      tb.rdata <= '0;
    end
  end

endmodule : lam_thr_regs

// >>> logic/lam_top.sv
// Purpose: Limit checking, alert pin and conversion mode control
// Assumes: Register port is the decoded serial access; ADC strobes share ref_clk
// Notes:   Read data appears two cycles after the read strobe
`timescale 1ns/1ps
module lam_top (
  // Clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    srst,
  // Register port
  input  wire logic [lam_pkg::AW-1:0]  reg_addr,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  input  wire logic [lam_pkg::DW-1:0]  reg_wdata,
  output logic      [lam_pkg::DW-1:0]  reg_rdata,
  output logic                         reg_rvalid,
  // Single-conversion results
  input  wire logic                    sample_strobe,
  input  wire logic [lam_pkg::DW-1:0]  raw_current,
  input  wire logic [lam_pkg::DW-1:0]  raw_vbus,
  input  wire logic [lam_pkg::DW-1:0]  raw_temp,
  input  wire logic [lam_pkg::DW-1:0]  raw_power,
  // Averaged results
  input  wire logic                    result_strobe,
  input  wire logic [lam_pkg::DW-1:0]  avg_current,
  input  wire logic [lam_pkg::DW-1:0]  avg_vbus,
  input  wire logic [lam_pkg::DW-1:0]  avg_temp,
  input  wire logic [lam_pkg::DW-1:0]  avg_power,
  // Datapath events
  input  wire logic                    conv_done,
  input  wire logic                    arith_ovf_evt,
  input  wire logic                    energy_ovf_evt,
  input  wire logic                    coulomb_ovf_evt,
  input  wire logic                    trim_status,
  // Converter control
  output logic                         adc_enable,
  output logic                         adc_restart,
  // Open-drain alert pin
  output logic                         alert_o,
  output logic                         alert_oe
);

  localparam int LIM_N = lam_pkg::NUM_THR;

  // Combined register reset
  logic                         soft_rst_q;
  logic                         rst_all;
  assign rst_all = srst | soft_rst_q;

  // Register access decode
  logic                         wr_gen;
  logic                         wr_conv;
  logic                         wr_diag;
  logic                         wr_thr;
  logic                         rd_diag;
  logic                         addr_is_thr;
  logic [lam_pkg::AW-1:0]       thr_off;
  logic [lam_pkg::CONV_MODE_W-1:0] new_mode;

  assign addr_is_thr = (reg_addr >= lam_pkg::ADDR_THR_BASE) && (reg_addr <= lam_pkg::ADDR_THR_LAST);
  assign thr_off     = reg_addr - lam_pkg::ADDR_THR_BASE;
  assign wr_gen      = reg_wr && (reg_addr == lam_pkg::ADDR_GENERAL_SETUP);
  assign wr_conv     = reg_wr && (reg_addr == lam_pkg::ADDR_CONV_SETUP);
  assign wr_diag     = reg_wr && (reg_addr == lam_pkg::ADDR_DIAG_FLAGS);
  assign wr_thr      = reg_wr && addr_is_thr;
  assign rd_diag     = reg_rd && (reg_addr == lam_pkg::ADDR_DIAG_FLAGS);
  assign new_mode    = reg_wdata[lam_pkg::CONV_MODE_LSB +: lam_pkg::CONV_MODE_W];

  // Threshold store
  lam_thr_if thr_bus ();

  assign thr_bus.clear = rst_all;
  assign thr_bus.we    = wr_thr;
  assign thr_bus.waddr = thr_off[lam_pkg::THR_IW-1:0];
  assign thr_bus.wdata = reg_wdata;
  assign thr_bus.raddr = thr_off[lam_pkg::THR_IW-1:0];

  lam_thr_regs u_thr (
    .ref_clk (ref_clk),
    .tb      (thr_bus)
  );

  // Soft reset pulse, self clearing
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= wr_gen && reg_wdata[lam_pkg::GEN_SOFT_RESET_BIT];
    end
  end

  // General setup storage; reset bit never stored
  logic [lam_pkg::DW-1:0]       gen_setup;
  always_ff @(posedge ref_clk) begin
    if (rst_all) begin
      gen_setup <= lam_pkg::GEN_SETUP_RST;
    end else if (wr_gen) begin
      gen_setup <= reg_wdata & ~(lam_pkg::DW'(1) << lam_pkg::GEN_SOFT_RESET_BIT);
    end
  end

  // Conversion setup storage
  logic [lam_pkg::DW-1:0]       conv_setup;
  always_ff @(posedge ref_clk) begin
    if (rst_all) begin
      conv_setup <= lam_pkg::CONV_SETUP_RST;
    end else if (wr_conv) begin
      conv_setup <= reg_wdata;
    end
  end

  // Alert configuration bits in diag flags
  logic                         hold_assert_enable;
  logic                         done_alert_enable;
  logic                         averaged_compare_enable;
  logic                         assert_level_select;
  always_ff @(posedge ref_clk) begin
    if (rst_all) begin
      {hold_assert_enable, done_alert_enable, averaged_compare_enable, assert_level_select}
        <= lam_pkg::DIAG_CTRL_RST;
    end else if (wr_diag) begin
      hold_assert_enable      <= reg_wdata[lam_pkg::DG_HOLD_EN];
      done_alert_enable       <= reg_wdata[lam_pkg::DG_DONE_AL_EN];
      averaged_compare_enable <= reg_wdata[lam_pkg::DG_AVG_CMP_EN];
      assert_level_select     <= reg_wdata[lam_pkg::DG_LEVEL_SEL];
    end
  end

  // Conversion mode machine
  lam_pkg::lam_conv_e           conv_state;
  lam_pkg::lam_conv_e           next_conv_state;

  always_comb begin
    next_conv_state = conv_state;
    if (wr_conv) begin
      case (new_mode)
        lam_pkg::MODE_TRIGGERED:  next_conv_state = lam_pkg::LAM_TRIG;
        lam_pkg::MODE_CONTINUOUS: next_conv_state = lam_pkg::LAM_CONT;
        default:                  next_conv_state = lam_pkg::LAM_SHUT;
      endcase
    end else begin
      case (conv_state)
        lam_pkg::LAM_TRIG: begin
          if (conv_done) begin
            next_conv_state = lam_pkg::LAM_SHUT;
          end
        end
        lam_pkg::LAM_CONT: next_conv_state = lam_pkg::LAM_CONT;
        lam_pkg::LAM_SHUT: next_conv_state = lam_pkg::LAM_SHUT;
        default:           next_conv_state = lam_pkg::LAM_SHUT;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst_all) begin
      conv_state <= lam_pkg::LAM_CONT;
    end else begin
      conv_state <= next_conv_state;
    end
  end

  // Converter control outputs
  always_ff @(posedge ref_clk) begin
    if (rst_all) begin
      adc_enable  <= 1'b0;
      adc_restart <= 1'b0;
    end else begin
      adc_enable  <= (next_conv_state != lam_pkg::LAM_SHUT);
      adc_restart <= wr_conv && (new_mode != lam_pkg::MODE_SHUTDOWN);
    end
  end

  // Compare source selection
  logic                         cmp_go;
  logic signed [lam_pkg::DW-1:0] c_cur;
  logic signed [lam_pkg::DW-1:0] c_vbus;
  logic signed [lam_pkg::DW-1:0] c_temp;
  logic signed [lam_pkg::DW-1:0] c_pwr;

  assign cmp_go = averaged_compare_enable ? result_strobe : sample_strobe;
  assign c_cur  = averaged_compare_enable ? avg_current : raw_current;
  assign c_vbus = averaged_compare_enable ? avg_vbus    : raw_vbus;
  assign c_temp = averaged_compare_enable ? avg_temp    : raw_temp;
  assign c_pwr  = averaged_compare_enable ? avg_power   : raw_power;

  // Signed limit comparisons
  logic [LIM_N-1:0]             cmp_hit;
  always_comb begin
    cmp_hit = '0;
    cmp_hit[lam_pkg::LF_CUR_UNDER]  = c_cur  < $signed(thr_bus.thr[lam_pkg::TH_CUR_LO]);
    cmp_hit[lam_pkg::LF_CUR_OVER]   = c_cur  > $signed(thr_bus.thr[lam_pkg::TH_CUR_HI]);
    cmp_hit[lam_pkg::LF_VBUS_HIGH]  = c_vbus > $signed(thr_bus.thr[lam_pkg::TH_VBUS_HI]);
    cmp_hit[lam_pkg::LF_VBUS_LOW]   = c_vbus < $signed(thr_bus.thr[lam_pkg::TH_VBUS_LO]);
    cmp_hit[lam_pkg::LF_DIE_HOT]    = c_temp > $signed(thr_bus.thr[lam_pkg::TH_DIE_HOT]);
    cmp_hit[lam_pkg::LF_PWR_EXCESS] = c_pwr  > $signed(thr_bus.thr[lam_pkg::TH_PWR_MAX]);
  end

  // Limit status flags
  logic [LIM_N-1:0]             lim_flags;
  always_ff @(posedge ref_clk) begin
    if (rst_all) begin
      lim_flags <= '0;
    end else if (hold_assert_enable) begin
      if (cmp_go) begin
        // New hit wins over a clearing read
        lim_flags <= (rd_diag ? '0 : lim_flags) | cmp_hit;
      end else if (rd_diag) begin
        lim_flags <= '0;
      end
    end else if (cmp_go) begin
      lim_flags <= cmp_hit;
    end
  end

  // Conversion done flag
  logic                         done_flag;
  logic                         done_clear;
  assign done_clear = (wr_conv && (new_mode != lam_pkg::MODE_SHUTDOWN)) || rd_diag;

  always_ff @(posedge ref_clk) begin
    if (rst_all) begin
      done_flag <= 1'b0;
    end else if (conv_done) begin
      done_flag <= 1'b1;
    end else if (done_clear) begin
      done_flag <= 1'b0;
    end
  end

  // Overflow flags, sticky until a diag read
  logic                         arith_overflow_flag;
  logic                         energy_accum_overflow_flag;
  logic                         coulomb_overflow_flag;
  always_ff @(posedge ref_clk) begin
    if (rst_all) begin
      arith_overflow_flag        <= 1'b0;
      energy_accum_overflow_flag <= 1'b0;
      coulomb_overflow_flag      <= 1'b0;
    end else begin
      arith_overflow_flag        <= arith_ovf_evt   | (arith_overflow_flag        & ~rd_diag);
      energy_accum_overflow_flag <= energy_ovf_evt  | (energy_accum_overflow_flag & ~rd_diag);
      coulomb_overflow_flag      <= coulomb_ovf_evt | (coulomb_overflow_flag      & ~rd_diag);
    end
  end

  // Trim memory health, from the same clock domain
  logic                         trim_memory_ok;
  always_ff @(posedge ref_clk) begin
    if (rst_all) begin
      trim_memory_ok <= 1'b0;
    end else begin
      trim_memory_ok <= trim_status;
    end
  end

  // Alert source: limits and done events only
  logic                         alert_raw;
  logic                         alert_hold;
  logic                         alert_act;
  assign alert_raw = (|lim_flags) | (done_alert_enable & done_flag);

  always_ff @(posedge ref_clk) begin
    if (rst_all) begin
      alert_hold <= 1'b0;
    end else if (hold_assert_enable && alert_raw && !rd_diag) begin
      alert_hold <= 1'b1;
    end else if (rd_diag || !hold_assert_enable) begin
      alert_hold <= 1'b0;
    end
  end

  assign alert_act = alert_raw | alert_hold;

  // Pin pulls low when the active level is low and alert is on, or vice versa
  always_ff @(posedge ref_clk) begin
    if (rst_all) begin
      alert_o  <= 1'b0;
      alert_oe <= 1'b0;
    end else begin
      alert_o  <= 1'b0;
      alert_oe <= alert_act ^ assert_level_select;
    end
  end

  // Diag flags read view
  logic [lam_pkg::DW-1:0]       diag_view;
  always_comb begin
    diag_view = '0;
    diag_view[lam_pkg::DG_HOLD_EN]     = hold_assert_enable;
    diag_view[lam_pkg::DG_DONE_AL_EN]  = done_alert_enable;
    diag_view[lam_pkg::DG_AVG_CMP_EN]  = averaged_compare_enable;
    diag_view[lam_pkg::DG_LEVEL_SEL]   = assert_level_select;
    diag_view[lam_pkg::DG_ENERGY_OVF]  = energy_accum_overflow_flag;
    diag_view[lam_pkg::DG_COULOMB_OVF] = coulomb_overflow_flag;
    diag_view[lam_pkg::DG_ARITH_OVF]   = arith_overflow_flag;
    diag_view[lam_pkg::DG_TRIM_OK]     = trim_memory_ok;
    diag_view[lam_pkg::DG_LIM_LSB +: LIM_N] = lim_flags;
    diag_view[lam_pkg::DG_DONE]        = done_flag;
  end

  // Read pipeline stage one
  logic [lam_pkg::DW-1:0]       rd_local;
  logic                         rd_sel_thr;
  logic                         rd_pend;
  always_ff @(posedge ref_clk) begin
    if (rst_all) begin
      rd_local   <= '0;
      rd_sel_thr <= 1'b0;
      rd_pend    <= 1'b0;
    end else begin
      rd_pend    <= reg_rd;
      rd_sel_thr <= addr_is_thr;
      if (reg_addr == lam_pkg::ADDR_GENERAL_SETUP) begin
        rd_local <= gen_setup;
      end else if (reg_addr == lam_pkg::ADDR_CONV_SETUP) begin
        rd_local <= conv_setup;
      end else if (reg_addr == lam_pkg::ADDR_DIAG_FLAGS) begin
        rd_local <= diag_view;
      end else begin
        rd_local <= '0;
      end
    end
  end

  // Read pipeline stage two
  always_ff @(posedge ref_clk) begin
    if (rst_all) begin
      reg_rdata  <= '0;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= rd_pend;
      if (rd_pend) begin
        reg_rdata <= rd_sel_thr ? thr_bus.rdata : rd_local;
      end
    end
  end

endmodule : lam_top

// >>> testbench/lam_checker_assertions.sv
// Purpose: Port-level checks of mode control, read timing and alert pin
// Assumes: Bound to lam_top, one clock domain
// Notes:   Tracks the last written mode field locally
`timescale 1ns/1ps
module lam_checker (
  // Clock and reset
  input wire logic                   ref_clk,
  input wire logic                   srst,
  // Register port
  input wire logic [lam_pkg::AW-1:0] reg_addr,
  input wire logic                   reg_wr,
  input wire logic                   reg_rd,
  input wire logic [lam_pkg::DW-1:0] reg_wdata,
  input wire logic                   reg_rvalid,
  // Converter and alert
  input wire logic                   conv_done,
  input wire logic                   adc_enable,
  input wire logic                   adc_restart,
  input wire logic                   alert_o,
  input wire logic                   alert_oe
);
  logic       cw;
  logic       sw;
  logic       rst_q;
  logic [1:0] md;
  logic [1:0] mode_q;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  assign cw = reg_wr && reg_addr == lam_pkg::ADDR_CONV_SETUP;
  assign sw = reg_wr && reg_addr == lam_pkg::ADDR_GENERAL_SETUP && reg_wdata[lam_pkg::GEN_SOFT_RESET_BIT];
  assign md = reg_wdata[1:0];
  // Last written mode field
  always_ff @(posedge ref_clk) begin
    if (srst || sw) begin
      mode_q <= lam_pkg::MODE_CONTINUOUS;
    end else if (cw) begin
      mode_q <= md;
    end
  end
  always_ff @(posedge ref_clk) begin
    rst_q <= srst;
  end
  a_shut_enter: assert property (cw && md == lam_pkg::MODE_SHUTDOWN |=> !adc_enable && !adc_restart)
    else $error("shutdown write left converter running");
  a_trig_start: assert property (cw && md == lam_pkg::MODE_TRIGGERED |=> adc_enable && adc_restart)
    else $error("triggered write did not start conversion");
  a_cont_start: assert property (cw && md == lam_pkg::MODE_CONTINUOUS |=> adc_enable && adc_restart)
    else $error("continuous write did not restart conversion");
  a_trig_return: assert property (mode_q == lam_pkg::MODE_TRIGGERED && conv_done && !reg_wr |=> !adc_enable)
    else $error("converter still on after triggered conversion");
  a_shut_hold: assert property (mode_q == lam_pkg::MODE_SHUTDOWN && !reg_wr |=> !adc_enable && !adc_restart)
    else $error("converter left shutdown without command");
  a_soft_reset: assert property (sw |-> ##[1:3] !adc_enable)
    else $error("soft reset did not reset converter state");
  a_read_lat: assert property (reg_rd |-> ##2 reg_rvalid)
    else $error("read answer missing two cycles after request");
  a_rvalid_src: assert property (reg_rvalid |-> $past(reg_rd, 2))
    else $error("read answer without request");
  a_open_drain: assert property (!alert_o)
    else $error("alert pin driven high");
  a_reset_idle: assert property (rst_q |-> !alert_oe && !reg_rvalid && !adc_enable && !adc_restart)
    else $error("outputs not at reset values after reset");
  c_trig_done: cover property (mode_q == lam_pkg::MODE_TRIGGERED && conv_done);
  c_soft_rst: cover property (sw);
  c_alert_on: cover property ($rose(alert_oe));
endmodule : lam_checker

bind lam_top lam_checker i_lam_checker (.ref_clk, .srst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rvalid,
  .conv_done, .adc_enable, .adc_restart, .alert_o, .alert_oe);

// >>> testbench/lam_host.sv
// Purpose: Host controller model on the register port and alert pin
// Assumes: Pull-up on the alert line
// Notes:   Requests change at the falling edge; released lines show inverted data
`timescale 1ns/1ps
module lam_host (
  // Clock
  input  wire logic                   ref_clk,
  // Register port
  output logic      [lam_pkg::AW-1:0] reg_addr,
  output logic                        reg_wr,
  output logic                        reg_rd,
  output logic      [lam_pkg::DW-1:0] reg_wdata,
  input  wire logic [lam_pkg::DW-1:0] reg_rdata,
  input  wire logic                   reg_rvalid,
  // Alert pin and status
  input  wire logic                   alert_o,
  input  wire logic                   alert_oe,
  output logic                        alert_pin,
  output logic                        timed_out
);
  assign alert_pin = alert_oe ? alert_o : 1'b1;
  initial begin
    {reg_addr, reg_wr, reg_rd, reg_wdata, timed_out} = '0;
  end
  task automatic wr(input logic [lam_pkg::AW-1:0] a, input logic [lam_pkg::DW-1:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [lam_pkg::AW-1:0] a, output logic [lam_pkg::DW-1:0] d);
    int i;
    d = 'x;
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    for (i = 0; i < 6; i++) begin
      @(posedge ref_clk);
      #1;
      if (reg_rvalid === 1'b1) begin
        d = reg_rdata;
        break;
      end
    end
    if (i == 6) timed_out = 1'b1;
  endtask : rd
endmodule : lam_host

// >>> testbench/test_limit_alert_and_power_modes.sv
// Purpose: Self-checking bench for limits, alert pin and conversion modes
// Assumes: Inputs change at the falling edge of ref_clk
// Notes:   Reference model kept in integers next to the stimulus
`timescale 1ns/1ps
module test_limit_alert_and_power_modes;
  logic        ref_clk = 1'b0;
  logic        srst, sample_strobe, result_strobe, conv_done, trim_status;
  logic        arith_ovf_evt, energy_ovf_evt, coulomb_ovf_evt;
  logic [15:0] raw_current, raw_vbus, raw_temp, raw_power;
  logic [15:0] avg_current, avg_vbus, avg_temp, avg_power;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic        reg_wr, reg_rd, reg_rvalid, adc_enable, adc_restart;
  logic        alert_o, alert_oe, alert_pin, timed_out;
  logic [3:0]  ctl;
  logic [2:0]  ovf;
  logic [5:0]  lim;
  logic        dn, held, trm;
  int          fail_count = 0;
  int          n_tests = 0;
  int          seed = 6873;
  int          i, k;
  int          thr[6];
  int          tv[6] = '{-100, 100, 1000, 100, 50, 500};
  logic [15:0] rv[6] = '{16'h8000, 16'h7FFF, 16'h7FFF, 16'h0000, 16'hFFFF, 16'h7FFF};
  localparam logic [7:0] DG = lam_pkg::ADDR_DIAG_FLAGS;
  localparam logic [7:0] CV = lam_pkg::ADDR_CONV_SETUP;

  lam_top i_lam_top (.ref_clk, .srst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid,
    .sample_strobe, .raw_current, .raw_vbus, .raw_temp, .raw_power, .result_strobe, .avg_current, .avg_vbus,
    .avg_temp, .avg_power, .conv_done, .arith_ovf_evt, .energy_ovf_evt, .coulomb_ovf_evt, .trim_status,
    .adc_enable, .adc_restart, .alert_o, .alert_oe);
  lam_host i_lam_host (.ref_clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid,
    .alert_o, .alert_oe, .alert_pin, .timed_out);

  always #10 ref_clk = ~ref_clk;

  function automatic logic [5:0] lims(int c, int v, int t, int p);
    return {p > thr[5], t > thr[4], v < thr[3], v > thr[2], c > thr[1], c < thr[0]};
  endfunction : lims
  function automatic logic act();
    return (|lim) | (ctl[2] & dn) | held;
  endfunction : act
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic pchk();
    held |= ctl[3] & act();
    repeat (2) @(negedge ref_clk);
    chk({15'h0, alert_pin}, {15'h0, (ctl[0] ? act() : !act())});
  endtask : pchk
  task automatic rdiag();
    i_lam_host.rd(DG, d);
    chk(d, {ctl, ovf, trm, lim, dn, 1'b0});
    {ovf, dn, held} = '0;
    if (ctl[3]) lim = '0;
  endtask : rdiag
  task automatic setc(input logic [3:0] c);
    ctl = c;
    i_lam_host.wr(DG, {c, 12'h000});
    held &= ctl[3];
    pchk();
  endtask : setc
  task automatic smp(input int c, input int v, input int t, input int p, input logic a);
    @(negedge ref_clk);
    // Unselected result set inverted so a wrong source shows
    {raw_current, raw_vbus, raw_temp, raw_power} = {c[15:0], v[15:0], t[15:0], p[15:0]} ^ {64{a}};
    {avg_current, avg_vbus, avg_temp, avg_power} = {c[15:0], v[15:0], t[15:0], p[15:0]} ^ {64{!a}};
    {sample_strobe, result_strobe} = {!a, a};
    @(negedge ref_clk);
    {sample_strobe, result_strobe} = 2'b00;
    {raw_current, raw_vbus, raw_temp, raw_power} = ~{raw_current, raw_vbus, raw_temp, raw_power};
    {avg_current, avg_vbus, avg_temp, avg_power} = ~{avg_current, avg_vbus, avg_temp, avg_power};
    if (a == ctl[1]) lim = ctl[3] ? (lim | lims(c, v, t, p)) : lims(c, v, t, p);
    pchk();
  endtask : smp
  task automatic ev(input logic [3:0] m);
    @(negedge ref_clk);
    {conv_done, arith_ovf_evt, energy_ovf_evt, coulomb_ovf_evt} = m;
    @(negedge ref_clk);
    {conv_done, arith_ovf_evt, energy_ovf_evt, coulomb_ovf_evt} = 4'h0;
    dn |= m[3];
    ovf |= {m[1], m[0], m[2]};
    pchk();
  endtask : ev
  task automatic wth(input int n, input logic [15:0] v);
    i_lam_host.wr(lam_pkg::ADDR_THR_BASE + n[7:0], v);
    thr[n] = $signed(v);
    i_lam_host.rd(lam_pkg::ADDR_THR_BASE + n[7:0], d);
    chk(d, v);
  endtask : wth
  task automatic rst_chk();
    for (i = 0; i < 6; i++) begin
      i_lam_host.rd(lam_pkg::ADDR_THR_BASE + i[7:0], d);
      chk(d, rv[i]);
      thr[i] = $signed(rv[i]);
    end
    i_lam_host.rd(CV, d);
    chk(d, 16'h0002);
    i_lam_host.rd(8'h05, d);
    chk(d, 16'h0000);
    {ctl, ovf, lim, dn, held} = '0;
    rdiag();
  endtask : rst_chk
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude

  always @(posedge timed_out) begin
    fail_count++;
    conclude();
  end

  initial begin
    {srst, sample_strobe, result_strobe, conv_done, arith_ovf_evt, energy_ovf_evt, coulomb_ovf_evt} = 7'h40;
    {raw_current, raw_vbus, raw_temp, raw_power, avg_current, avg_vbus, avg_temp, avg_power} = '0;
    trim_status = 1'b1;
    trm = 1'b1;
    repeat (6) @(negedge ref_clk);
    srst = 1'b0;
    rst_chk();
    $display("test reset done");
    for (k = 0; k < 6; k++) wth(k, 16'($random(seed)));
    for (k = 0; k < 6; k++) wth(k, 16'(tv[k]));
    repeat (24) begin
      smp($random(seed) % 2048, $random(seed) % 2048, $random(seed) % 128, $random(seed) % 2048, 1'b0);
      rdiag();
    end
    smp(0, 500, 0, 0, 1'b0);
    $display("test compare done");
    setc(4'h2);
    smp(5000, 500, 0, 0, 1'b0);
    rdiag();
    smp(5000, 500, 0, 0, 1'b1);
    rdiag();
    smp(0, 500, 0, 0, 1'b1);
    setc(4'h8);
    smp(-5000, 500, 0, 0, 1'b0);
    smp(0, 500, 0, 0, 1'b0);
    rdiag();
    pchk();
    setc(4'h0);
    ev(4'h8);
    rdiag();
    setc(4'h4);
    ev(4'h8);
    i_lam_host.wr(CV, 16'h0002);
    dn = 1'b0;
    rdiag();
    smp(5000, 500, 0, 0, 1'b0);
    ev(4'h8);
    rdiag();
    smp(0, 500, 0, 0, 1'b0);
    setc(4'h1);
    smp(0, 5000, 0, 0, 1'b0);
    smp(0, 500, 0, 0, 1'b0);
    setc(4'h0);
    trim_status = 1'b0;
    trm = 1'b0;
    ev(4'h7);
    rdiag();
    @(negedge ref_clk);
    trim_status = 1'b1;
    trm = 1'b1;
    $display("test alert done");
    ev(4'h8);
    i_lam_host.wr(CV, 16'h0000);
    chk({15'h0, adc_enable}, 16'h0000);
    rdiag();
    wth(0, 16'h1234);
    i_lam_host.wr(CV, 16'h0001);
    chk({15'h0, adc_enable}, 16'h0001);
    ev(4'h8);
    chk({15'h0, adc_enable}, 16'h0000);
    i_lam_host.rd(CV, d);
    chk(d, 16'h0001);
    i_lam_host.wr(CV, 16'h0002);
    dn = 1'b0;
    chk({15'h0, adc_enable}, 16'h0001);
    $display("test modes done");
    i_lam_host.wr(lam_pkg::ADDR_GENERAL_SETUP, 16'h8000);
    repeat (2) @(negedge ref_clk);
    rst_chk();
    wth(1, 16'h0005);
    @(negedge ref_clk);
    srst = 1'b1;
    repeat (2) @(negedge ref_clk);
    srst = 1'b0;
    rst_chk();
    $display("test resets done");
    conclude();
  end
endmodule : test_limit_alert_and_power_modes
